// File: include/dgt_defs.svh
`ifndef DGT_DEFS_SVH
`define DGT_DEFS_SVH

// byte addresses on the register port
`define DGT_A_LOAD      32'hFFFF_0300
`define DGT_A_VAL_LO    32'hFFFF_0304
`define DGT_A_VAL_HI    32'hFFFF_0308
`define DGT_A_CTRL      32'hFFFF_030C
`define DGT_A_RELOAD    32'hFFFF_0310
`define DGT_B_LOAD      32'hFFFF_0320
`define DGT_B_VALUE     32'hFFFF_0324
`define DGT_B_CTRL      32'hFFFF_0328
`define DGT_B_IRQ_CLR   32'hFFFF_032C
`define DGT_B_SNAP      32'hFFFF_0330

// control fields
`define DGT_CAP_EN      17
`define DGT_EVT_HI      16
`define DGT_EVT_LO      12
`define DGT_SRC_HI      11
`define DGT_SRC_LO      9
`define DGT_UP          8
`define DGT_EN          7
`define DGT_PERIODIC    6
`define DGT_FMT_HI      5
`define DGT_FMT_LO      4
`define DGT_WIDE        4
`define DGT_PRE_HI      3
`define DGT_CTRL_HI     17

// writable bits of each control register
`define DGT_A_CTRL_MASK 18'h3_F1DF
`define DGT_B_CTRL_MASK 18'h3_FFFF
`define DGT_RESET_VAL   32'h0000_0000

// prescaler decode and time-of-day limits
`define DGT_PRE_DIV1    4'h0
`define DGT_PRE_DIV16   4'h4
`define DGT_PRE_DIV256  4'h8
`define DGT_PRE_DIV32K  4'hF
`define DGT_HUND_MAX    8'h63
`define DGT_MINSEC_MAX  8'h3B
`define DGT_HOUR23_MAX  8'h17
`define DGT_HOUR255_MAX 8'hFF

`endif

// File: include/dgt_pkg.sv
`default_nettype none
package dgt_pkg;

    typedef enum logic [2:0] {
        DGT_SRC_CORE  = 3'h0,
        DGT_SRC_OSC   = 3'h1,
        DGT_SRC_GPIO1 = 3'h2,
        DGT_SRC_GPIO2 = 3'h3
    } dgt_src_e;

    typedef enum logic [1:0] {
        DGT_FMT_BIN   = 2'h0,
        DGT_FMT_RSVD  = 2'h1,
        DGT_FMT_HMS23 = 2'h2,
        DGT_FMT_HMS255 = 2'h3
    } dgt_fmt_e;

endpackage
`default_nettype wire

// File: verif/dgt_core_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "dgt_defs.svh"

module dgt_core_model (
    // clock
    input  wire logic        clk,
    // register port
    output logic      [31:0] reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    initial
    begin
        reg_addr  = 32'h0000_0000;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    task automatic write(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] d;
        d = data;
        if (addr == `DGT_B_CTRL)
            d = data & 32'h0003_FFFF;
        @(posedge clk);
        reg_addr  <= addr;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // data is taken at the edge that closes the answer cycle
    task automatic read(input logic [31:0] addr, output logic [31:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(posedge clk);
        data = reg_rdata;
    endtask
endmodule

`default_nettype wire

// File: verif/dgt_timers_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "dgt_defs.svh"

module dgt_timers_bench
    import dgt_pkg::*;
();
    logic        clk;
    logic        nrst;
    logic [31:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        osc_32k;
    logic        first_gpio_clock_pin;
    logic        second_gpio_clock_pin;
    logic        low_power;
    logic [31:0] event_src;
    logic        timer_a_irq;
    logic        timer_b_irq;
    int          errors;
    int          total_checks;
    int          seed;
    int          exp_q[$];

    localparam logic [31:0] RST_ADDR [9] = '{`DGT_A_LOAD, `DGT_A_VAL_LO, `DGT_A_VAL_HI,
        `DGT_A_CTRL, `DGT_B_LOAD, `DGT_B_VALUE, `DGT_B_CTRL, `DGT_B_SNAP, 32'hFFFF_0334};
    localparam logic [31:0] P_CTRL [11] = '{32'h0000_00C0, 32'h0000_01C0, 32'h0000_00C4,
        32'h0000_00C8, 32'h0000_00CF, 32'h0000_00C0, 32'h0000_01C4, 32'h0000_0080,
        32'h0000_0180, 32'h0000_01E0, 32'h0000_00F0};
    localparam logic [31:0] P_LOAD [11] = '{32'h0000_0003, 32'hFFFF_FFFC, 32'h0000_0003,
        32'h0000_0003, 32'h0000_0000, 32'h0000_0003, 32'h0000_FFFC, 32'h0000_0002,
        32'hFFFF_FFFE, 32'h173B_3A63, 32'h0000_0100};
    localparam logic        P_A [11] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
        1'b0, 1'b0, 1'b0};

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    dgt_core_model dgt_core_model_inst (
        .clk       (clk),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata)
    );

    dgt_timers #(.EVT_W(32)) dgt_timers_inst (
        .clk                   (clk),
        .nrst                  (nrst),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .osc_32k               (osc_32k),
        .first_gpio_clock_pin  (first_gpio_clock_pin),
        .second_gpio_clock_pin (second_gpio_clock_pin),
        .low_power             (low_power),
        .event_src             (event_src),
        .timer_a_irq           (timer_a_irq),
        .timer_b_irq           (timer_b_irq)
    );

    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp)
        begin
            errors++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    function automatic logic irq_of(input logic is_a);
        return is_a ? timer_a_irq : timer_b_irq;
    endfunction

    // cycles between two interrupts, with the clear written right after the first
    function automatic int period(input logic [31:0] ctrl, input logic [31:0] ld,
                                  input logic is_a);
        int div;
        int steps;
        int at;
        div = (ctrl[3:0] == 4'h4) ? 16 : (ctrl[3:0] == 4'h8) ? 256 :
              (ctrl[3:0] == 4'hF) ? 32768 : 1;
        steps = ctrl[8] ? int'((is_a ? 32'h0000_FFFF : 32'hFFFF_FFFF) - ld) : int'(ld);
        // time-of-day formats step in hundredths up to the last hour's final tick
        if (ctrl[5] && !is_a)
        begin
            at = ((int'(ld[31:24]) * 60 + int'(ld[23:16])) * 60 + int'(ld[15:8])) * 100
                 + int'(ld[7:0]);
            steps = ctrl[8] ? (ctrl[4] ? 256 : 24) * 360000 - 1 - at : at;
        end
        return (div == 1) ? steps + 3 : (steps + 1) * div;
    endfunction

    task automatic wait_irq(input logic is_a, inout int n);
        int k;
        k = 0;
        while (irq_of(is_a) !== 1'b1 && k < 70000)
        begin
            @(posedge clk);
            #1;
            n++;
            k++;
        end
        if (k == 70000)
        begin
            errors++;
            $display("[FAIL] interrupt wait expected 1 seen 0");
            complete_run();
        end
    endtask

    task automatic pulse_pin(input int s);
        repeat (4)
        begin
            @(posedge clk);
            {osc_32k, first_gpio_clock_pin, second_gpio_clock_pin} <=
                (s == 0) ? 3'b000 : 3'(4 >> (s - 1));
            repeat (3) @(posedge clk);
            {osc_32k, first_gpio_clock_pin, second_gpio_clock_pin} <= 3'b000;
            repeat (3) @(posedge clk);
        end
    endtask

    initial
    begin
        logic [31:0] d;
        logic [31:0] v;
        logic [31:0] snap;
        logic [4:0]  sel;
        logic        is_a;
        int          n;
        nrst = 1'b0;
        osc_32k = 1'b0;
        first_gpio_clock_pin = 1'b0;
        second_gpio_clock_pin = 1'b0;
        low_power = 1'b0;
        event_src = 32'h0000_0000;
        errors = 0;
        total_checks = 0;
        seed = 32'hedc0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (RST_ADDR[i])
        begin
            dgt_core_model_inst.read(RST_ADDR[i], d);
            check_word("reset value", 32'h0000_0000, d);
        end
        dgt_core_model_inst.write(`DGT_A_CTRL, 32'hFFFF_FF7F);
        dgt_core_model_inst.read(`DGT_A_CTRL, d);
        check_word("timer a control", 32'h0003_F15F, d);
        dgt_core_model_inst.write(`DGT_A_CTRL, 32'h0000_0000);
        dgt_core_model_inst.write(`DGT_A_LOAD, 32'hFFFF_ABCD);
        dgt_core_model_inst.read(`DGT_A_LOAD, d);
        check_word("timer a load", 32'h0000_ABCD, d);
        dgt_core_model_inst.write(`DGT_A_RELOAD, 32'h0000_0000);
        dgt_core_model_inst.read(`DGT_A_VAL_LO, d);
        check_word("timer a value", 32'h0000_ABCD, d);
        dgt_core_model_inst.write(`DGT_B_LOAD, 32'h1234_5678);
        dgt_core_model_inst.read(`DGT_B_LOAD, d);
        check_word("timer b load", 32'h1234_5678, d);
        dgt_core_model_inst.write(`DGT_B_IRQ_CLR, 32'h0000_00FF);
        dgt_core_model_inst.write(`DGT_B_VALUE, 32'h0000_0000);
        dgt_core_model_inst.write(32'hFFFF_0334, 32'hFFFF_FFFF);
        dgt_core_model_inst.read(`DGT_B_VALUE, d);
        check_word("timer b value", 32'h1234_5678, d);
        dgt_core_model_inst.read(32'hFFFF_0334, d);
        check_word("unmapped", 32'h0000_0000, d);
        // interrupt spacing per mode, direction and prescale
        foreach (P_CTRL[i])
        begin
            is_a = P_A[i];
            exp_q.push_back(period(P_CTRL[i], P_LOAD[i], is_a));
            dgt_core_model_inst.write(`DGT_A_CTRL, 32'h0000_0000);
            dgt_core_model_inst.write(`DGT_B_CTRL, 32'h0000_0000);
            dgt_core_model_inst.write(is_a ? `DGT_A_LOAD : `DGT_B_LOAD, P_LOAD[i]);
            dgt_core_model_inst.write(is_a ? `DGT_A_RELOAD : `DGT_B_IRQ_CLR, 32'h0000_00A5);
            dgt_core_model_inst.write(is_a ? `DGT_A_CTRL : `DGT_B_CTRL, P_CTRL[i]);
            n = 0;
            wait_irq(is_a, n);
            dgt_core_model_inst.write(is_a ? `DGT_A_RELOAD : `DGT_B_IRQ_CLR, 32'h0000_005A);
            #1;
            check_word("irq after clear", 32'h0000_0000, {31'h0, irq_of(is_a)});
            n = 2;
            wait_irq(is_a, n);
            check_count("irq period", exp_q.pop_front(), n);
        end
        // wide mode counts up from zero even with the up bit clear
        dgt_core_model_inst.write(`DGT_A_CTRL, 32'h0000_0090);
        dgt_core_model_inst.write(`DGT_A_RELOAD, 32'h0000_0000);
        dgt_core_model_inst.read(`DGT_A_VAL_LO, d);
        check_word("timer a wide low", 32'h0000_0001, d);
        dgt_core_model_inst.read(`DGT_A_VAL_HI, d);
        check_word("timer a wide high", 32'h0000_0000, d);
        // clock sources while in low power
        dgt_core_model_inst.write(`DGT_A_CTRL, 32'h0000_0000);
        low_power <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            dgt_core_model_inst.write(`DGT_B_CTRL, 32'h0000_0000);
            dgt_core_model_inst.write(`DGT_B_LOAD, 32'h0000_000A);
            dgt_core_model_inst.write(`DGT_B_IRQ_CLR, 32'h0000_0000);
            dgt_core_model_inst.write(`DGT_B_CTRL, 32'h0000_0080 | (32'(s) << 9));
            pulse_pin(s);
            repeat (5) @(posedge clk);
            dgt_core_model_inst.read(`DGT_B_VALUE, d);
            check_word("source count", (s == int'(DGT_SRC_CORE)) ? 32'hA : 32'h6, d);
        end
        low_power <= 1'b0;
        // event capture, enabled and disabled
        snap = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            sel = 5'($random(seed));
            dgt_core_model_inst.write(`DGT_B_CTRL, 32'h0000_0000);
            dgt_core_model_inst.write(`DGT_B_LOAD, v);
            dgt_core_model_inst.write(`DGT_B_IRQ_CLR, 32'h0000_0000);
            // core clock, down one per cycle: the capture lands four steps in
            dgt_core_model_inst.write(`DGT_B_CTRL, {14'h0, (i != 1), sel, 12'h080});
            @(posedge clk);
            event_src <= 32'h1 << (sel + 5'd1);
            repeat (3) @(posedge clk);
            event_src <= 32'h1 << sel;
            repeat (3) @(posedge clk);
            event_src <= 32'h0000_0000;
            if (i != 1)
                snap = v - 32'h0000_0004;
            dgt_core_model_inst.read(`DGT_B_SNAP, d);
            check_word("snapshot", snap, d);
            dgt_core_model_inst.read(`DGT_B_VALUE, d);
            check_word("value running", v - 32'h0000_000B, d);
        end
        complete_run();
    end
endmodule

`default_nettype wire

// File: verilog/dgt_timers.sv
`timescale 1ns/1ns
`default_nettype none
`include "dgt_defs.svh"

module dgt_timers
    import dgt_pkg::*;
#(
    parameter int EVT_W = 32
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // clock sources and power state
    input  wire logic        osc_32k,
    input  wire logic        first_gpio_clock_pin,
    input  wire logic        second_gpio_clock_pin,
    input  wire logic        low_power,
    // capture event sources
    input  wire logic [EVT_W-1:0] event_src,
    // timer interrupts
    output logic             timer_a_irq,
    output logic             timer_b_irq
);

    // the select field is five bits wide, so no other source count can be served
    if (EVT_W != 32)
    begin
        $error("dgt_timers: event select is five bits wide, EVT_W must be 32");
    end

    function automatic logic [14:0] presc_mask(input logic [3:0] code);
        unique case (code)
            `DGT_PRE_DIV16:  presc_mask = 15'h000F;
            `DGT_PRE_DIV256: presc_mask = 15'h00FF;
            `DGT_PRE_DIV32K: presc_mask = 15'h7FFF;
            default:         presc_mask = 15'h0000;
        endcase
    endfunction

    function automatic logic [31:0] b_full(input logic [1:0] fmt);
        unique case (fmt)
            DGT_FMT_HMS23:  b_full = {`DGT_HOUR23_MAX, `DGT_MINSEC_MAX, `DGT_MINSEC_MAX,
                                      `DGT_HUND_MAX};
            DGT_FMT_HMS255: b_full = {`DGT_HOUR255_MAX, `DGT_MINSEC_MAX, `DGT_MINSEC_MAX,
                                      `DGT_HUND_MAX};
            default:        b_full = 32'hFFFF_FFFF;
        endcase
    endfunction

    // one step of an hours:minutes:seconds:hundredths count, binary fields
    function automatic logic [31:0] hms_step(input logic [31:0] v, input logic up,
                                             input logic [7:0] hmax);
        logic [7:0] h;
        logic [7:0] m;
        logic [7:0] s;
        logic [7:0] c;
        h = v[31:24];
        m = v[23:16];
        s = v[15:8];
        c = v[7:0];
        if (up)
        begin
            if (c != `DGT_HUND_MAX) c = c + 8'h01;
            else
            begin
                c = 8'h00;
                if (s != `DGT_MINSEC_MAX) s = s + 8'h01;
                else
                begin
                    s = 8'h00;
                    if (m != `DGT_MINSEC_MAX) m = m + 8'h01;
                    else
                    begin
                        m = 8'h00;
                        h = (h == hmax) ? 8'h00 : h + 8'h01;
                    end
                end
            end
        end
        else
        begin
            if (c != 8'h00) c = c - 8'h01;
            else
            begin
                c = `DGT_HUND_MAX;
                if (s != 8'h00) s = s - 8'h01;
                else
                begin
                    s = `DGT_MINSEC_MAX;
                    if (m != 8'h00) m = m - 8'h01;
                    else
                    begin
                        m = `DGT_MINSEC_MAX;
                        h = (h == 8'h00) ? hmax : h - 8'h01;
                    end
                end
            end
        end
        hms_step = {h, m, s, c};
    endfunction

    logic [15:0]       timer_a_load_r;
    logic [17:0]       timer_a_control_r;
    logic [15:0]       timer_a_value_low_r;
    logic [31:0]       timer_a_value_high_r;
    logic [31:0]       timer_b_load_r;
    logic [17:0]       timer_b_control_r;
    logic [31:0]       timer_b_value_r;
    logic [31:0]       timer_b_snapshot_r;
    logic              irq_a_r;
    logic              irq_b_r;
    logic [31:0]       rdata_r;
    logic [14:0]       pre_a_r;
    logic [14:0]       pre_b_r;
    logic [2:0]        sync1_r;
    logic [2:0]        sync2_r;
    logic [2:0]        sync3_r;
    logic [EVT_W-1:0]  evt_prev_r;

    logic wr_a_load, wr_a_ctrl, wr_a_reload, wr_b_load, wr_b_ctrl, wr_b_clr;
    assign wr_a_load   = reg_wr && (reg_addr == `DGT_A_LOAD);
    assign wr_a_ctrl   = reg_wr && (reg_addr == `DGT_A_CTRL);
    assign wr_a_reload = reg_wr && (reg_addr == `DGT_A_RELOAD);
    assign wr_b_load   = reg_wr && (reg_addr == `DGT_B_LOAD);
    assign wr_b_ctrl   = reg_wr && (reg_addr == `DGT_B_CTRL);
    assign wr_b_clr    = reg_wr && (reg_addr == `DGT_B_IRQ_CLR);

    // register writes; reserved bits are masked off, not trusted to be zero
    // reserved bits
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            timer_a_load_r    <= 16'h0000;
            timer_a_control_r <= 18'h0_0000;
            timer_b_load_r    <= `DGT_RESET_VAL;
            timer_b_control_r <= 18'h0_0000;
        end
        else
        begin
            if (wr_a_load) timer_a_load_r <= reg_wdata[15:0];
            if (wr_a_ctrl) timer_a_control_r <= reg_wdata[17:0] & `DGT_A_CTRL_MASK;
            if (wr_b_load) timer_b_load_r <= reg_wdata;
            if (wr_b_ctrl) timer_b_control_r <= reg_wdata[17:0] & `DGT_B_CTRL_MASK;
        end
    end

    // read data stand only in the cycle after the read strobe
    // read-only registers
    always_ff @(posedge clk)
    begin
        if (!nrst) rdata_r <= 32'h0000_0000;
        else if (!reg_rd) rdata_r <= 32'h0000_0000;
        else
        begin
            unique case (reg_addr)
                `DGT_A_LOAD:    rdata_r <= {16'h0000, timer_a_load_r};
                `DGT_A_VAL_LO:  rdata_r <= {16'h0000, timer_a_value_low_r};
                `DGT_A_VAL_HI:  rdata_r <= timer_a_value_high_r;
                `DGT_A_CTRL:    rdata_r <= {14'h0000, timer_a_control_r};
                `DGT_B_LOAD:    rdata_r <= timer_b_load_r;
                `DGT_B_VALUE:   rdata_r <= timer_b_value_r;
                `DGT_B_CTRL:    rdata_r <= {14'h0000, timer_b_control_r};
                `DGT_B_SNAP:    rdata_r <= timer_b_snapshot_r;
                default:        rdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign reg_rdata = rdata_r;

    // pin synchroniser, edge taken after the second stage
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
            sync3_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {second_gpio_clock_pin, first_gpio_clock_pin, osc_32k};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    logic [2:0] src_rise;
    assign src_rise = sync2_r & ~sync3_r;

    // core source halts in low power, others run on
    logic src_b;
    always_comb
    begin
        unique case (timer_b_control_r[`DGT_SRC_HI:`DGT_SRC_LO])
            DGT_SRC_CORE:  src_b = !low_power;
            DGT_SRC_OSC:   src_b = src_rise[0];
            DGT_SRC_GPIO1: src_b = src_rise[1];
            DGT_SRC_GPIO2: src_b = src_rise[2];
            default:       src_b = 1'b0;
        endcase
    end

    logic src_a;
    assign src_a = !low_power;

    logic tick_a;
    logic tick_b;
    assign tick_a = timer_a_control_r[`DGT_EN] && src_a
                    && ((pre_a_r & presc_mask(timer_a_control_r[`DGT_PRE_HI:0]))
                        == presc_mask(timer_a_control_r[`DGT_PRE_HI:0]));
    assign tick_b = timer_b_control_r[`DGT_EN] && src_b
                    && ((pre_b_r & presc_mask(timer_b_control_r[`DGT_PRE_HI:0]))
                        == presc_mask(timer_b_control_r[`DGT_PRE_HI:0]));

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pre_a_r <= 15'h0000;
            pre_b_r <= 15'h0000;
        end
        else
        begin
            if (timer_a_control_r[`DGT_EN] && src_a) pre_a_r <= pre_a_r + 15'h0001;
            if (timer_b_control_r[`DGT_EN] && src_b) pre_b_r <= pre_b_r + 15'h0001;
        end
    end

    // timer A terminal detection
    logic a_wide;
    logic a_up;
    logic a_term;
    assign a_wide = timer_a_control_r[`DGT_WIDE];
    assign a_up   = timer_a_control_r[`DGT_UP] || a_wide;
    assign a_term = a_wide ? ({timer_a_value_high_r, timer_a_value_low_r} == 48'hFFFF_FFFF_FFFF)
                           : (a_up ? (timer_a_value_low_r == 16'hFFFF)
                                   : (timer_a_value_low_r == 16'h0000));

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            timer_a_value_low_r  <= 16'h0000;
            timer_a_value_high_r <= 32'h0000_0000;
        end
        else if (wr_a_reload)
        begin
            timer_a_value_low_r  <= a_wide ? 16'h0000 : timer_a_load_r;
            timer_a_value_high_r <= 32'h0000_0000;
        end
        else if (tick_a)
        begin
            if (a_wide)
                {timer_a_value_high_r, timer_a_value_low_r} <=
                    {timer_a_value_high_r, timer_a_value_low_r} + 48'h0000_0000_0001;
            else if (a_term)
                timer_a_value_low_r <= timer_a_control_r[`DGT_PERIODIC] ? timer_a_load_r
                                       : (a_up ? 16'h0000 : 16'hFFFF);
            else if (a_up)
                timer_a_value_low_r <= timer_a_value_low_r + 16'h0001;
            else
                timer_a_value_low_r <= timer_a_value_low_r - 16'h0001;
        end
    end

    // timer B
    logic [1:0]  b_fmt;
    logic        b_up;
    logic        b_hms;
    logic        b_term;
    logic [31:0] b_max;
    assign b_fmt  = timer_b_control_r[`DGT_FMT_HI:`DGT_FMT_LO];
    assign b_up   = timer_b_control_r[`DGT_UP];
    assign b_hms  = b_fmt[1];
    assign b_max  = b_full(b_fmt);
    assign b_term = b_up ? (timer_b_value_r == b_max) : (timer_b_value_r == 32'h0000_0000);

    always_ff @(posedge clk)
    begin
        if (!nrst) timer_b_value_r <= `DGT_RESET_VAL;
        else if (wr_b_clr) timer_b_value_r <= timer_b_load_r;
        else if (tick_b)
        begin
            if (b_term)
                timer_b_value_r <= timer_b_control_r[`DGT_PERIODIC] ? timer_b_load_r
                                   : (b_up ? 32'h0000_0000 : b_max);
            else if (b_hms)
                timer_b_value_r <= hms_step(timer_b_value_r, b_up, b_max[31:24]);
            else if (b_up)
                timer_b_value_r <= timer_b_value_r + 32'h0000_0001;
            else
                timer_b_value_r <= timer_b_value_r - 32'h0000_0001;
        end
    end

    // capture on every rise of the selected event source
    logic b_evt_rise;
    assign b_evt_rise = event_src[timer_b_control_r[`DGT_EVT_HI:`DGT_EVT_LO]]
                        && !evt_prev_r[timer_b_control_r[`DGT_EVT_HI:`DGT_EVT_LO]];

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            evt_prev_r         <= '0;
            timer_b_snapshot_r <= 32'h0000_0000;
        end
        else
        begin
            evt_prev_r <= event_src;
            if (timer_b_control_r[`DGT_CAP_EN] && b_evt_rise)
                timer_b_snapshot_r <= timer_b_value_r;
        end
    end

    // interrupt flags: a terminal tick in the clearing cycle still sets B; for A the reload write wins
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            irq_a_r <= 1'b0;
            irq_b_r <= 1'b0;
        end
        else
        begin
            if (tick_a && a_term && !wr_a_reload) irq_a_r <= 1'b1;
            else if (wr_a_reload) irq_a_r <= 1'b0;
            if (tick_b && b_term) irq_b_r <= 1'b1;
            else if (wr_b_clr) irq_b_r <= 1'b0;
        end
    end
    assign timer_a_irq = irq_a_r;
    assign timer_b_irq = irq_b_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_b_clear;
        reg_wr && (reg_addr == `DGT_B_IRQ_CLR);
    endsequence
    sequence s_b_wrap_periodic;
        tick_b && b_term && timer_b_control_r[`DGT_PERIODIC] && !wr_b_clr;
    endsequence

    a_b_clear_reload: assert property (s_b_clear |=> timer_b_value_r == $past(timer_b_load_r))
        else $error("timer B not reloaded by clear write");
    a_b_irq_clear: assert property (s_b_clear ##0 !(tick_b && b_term) |=> !timer_b_irq)
        else $error("timer B interrupt not cleared");
    a_b_periodic_load: assert property (s_b_wrap_periodic
            |=> timer_b_value_r == $past(timer_b_load_r) && timer_b_irq)
        else $error("timer B periodic restart wrong");
    a_b_snapshot_copy: assert property (timer_b_control_r[`DGT_CAP_EN] && b_evt_rise
            |=> timer_b_snapshot_r == $past(timer_b_value_r))
        else $error("timer B snapshot not taken");
    a_b_disabled_hold: assert property (!timer_b_control_r[`DGT_EN] && !wr_b_clr
            |=> $stable(timer_b_value_r))
        else $error("disabled timer B moved");
    a_a_down_wrap: assert property (tick_a && !a_wide && !a_up && a_term && !wr_a_reload
            && !timer_a_control_r[`DGT_PERIODIC]
            |=> timer_a_value_low_r == 16'hFFFF && timer_a_irq)
        else $error("timer A free-running down wrap wrong");
    a_a_reload_strobe: assert property (wr_a_reload && !a_wide
            |=> timer_a_value_low_r == $past(timer_a_load_r) && !timer_a_irq)
        else $error("timer A reload strobe ignored");
    a_a_stopped_hold: assert property (!timer_a_control_r[`DGT_EN] && !wr_a_reload
            |=> $stable(timer_a_value_low_r) && $stable(timer_a_value_high_r))
        else $error("stopped timer A moved");
    a_rd_only_after: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");
    a_b_sleep_core: assert property (low_power && timer_b_control_r[`DGT_SRC_HI:`DGT_SRC_LO]
            == DGT_SRC_CORE && !wr_b_clr |=> $stable(timer_b_value_r))
        else $error("core-clocked timer B ran in low power");

endmodule

`default_nettype wire
